// *** hw/wss_top.sv ***
// Safe-state (auto-shutdown) control for the four waveform outputs A to D
// Function
// R1: While shut down, outputs B and D follow the B/D select field: 11 high, 10 low, 01 tri-state, 00 inactive level after dead-band.
// R2: While shut down, outputs A and C follow the A/C select field with the same four encodings.
// R3: Bit 6 enables auto-restart; when clear, software must clear the shutdown bit to recover.
// R4: Software may write the shutdown bit while the generator is disabled to force the safe state.
// R5: After the shutdown bit clears, outputs stay safe until the next rising edge of the generator input.
// R6: A shutdown event sets the shutdown bit in hardware, and with auto-restart the bit clears once the event is gone (code: only while enabled).
//
// The register addresses and the strobed register port were left to the implementer.
module wss_top
    import wss_pkg::*;
(
    input  wire logic              clk_sys_in,
    input  wire logic              rst_b_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    output logic      [DATA_W-1:0] rdata_out,
    input  wire logic              shutdown_evt_in,
    input  wire logic              wave_src_in,
    output logic                   output_a_out,
    output logic                   output_a_oe_out,
    output logic                   output_b_out,
    output logic                   output_b_oe_out,
    output logic                   output_c_out,
    output logic                   output_c_oe_out,
    output logic                   output_d_out,
    output logic                   output_d_oe_out,
    output logic                   irq_out
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [1:0] sync1_ff;
    logic [1:0] sync2_ff;
    logic       src_prev_ff;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            sync1_ff    <= 2'h0;
            sync2_ff    <= 2'h0;
            src_prev_ff <= 1'b0;
        end else begin
            sync1_ff    <= {shutdown_evt_in, wave_src_in};
            sync2_ff    <= sync1_ff;
            src_prev_ff <= sync2_ff[0];
        end
    end

    wire logic evt     = sync2_ff[1];
    wire logic src     = sync2_ff[0];
    wire logic src_ris = src & ~src_prev_ff;

    // ----------------------------------------------------------------
    // Registers and bus decode
    // ----------------------------------------------------------------
    wss_ctrl_s          ctrl_ff;
    wss_cfg_s           cfg_ff;
    logic [DBAND_W-1:0] dband_ff;
    logic [IRQ_W-1:0]   istat_ff;
    logic [IRQ_W-1:0]   imask_ff;
    wss_state_e         state_ff;
    wss_state_e         nxt_state;

    wire logic wr_ctrl  = wr_in && (addr_in == OFF_CTRL);
    wire logic wr_cfg   = wr_in && (addr_in == OFF_CFG);
    wire logic wr_dband = wr_in && (addr_in == OFF_DBAND);
    wire logic wr_imask = wr_in && (addr_in == OFF_IMASK);
    wire logic rd_istat = rd_in && (addr_in == OFF_ISTAT);

    // Setting by software only while disabled; clearing is allowed unless the event input is high
    wire logic sw_sd_take = wr_ctrl && (!cfg_ff.enable || !wdata_in[CTRL_SD_BIT]); // R4 R3
    // Auto clear is limited to a running generator so a forced shutdown holds
    wire logic auto_clr   = ctrl_ff.restart_en && cfg_ff.enable && !evt; // R3 R6
    wire logic nxt_sd     = evt ? 1'b1 :                                   // R6
                            sw_sd_take ? wdata_in[CTRL_SD_BIT] :           // R4
                            auto_clr ? 1'b0 : ctrl_ff.shutdown;

    wire logic enter_shut = (state_ff != ST_SHUT) && (nxt_state == ST_SHUT);
    wire logic resume     = (state_ff == ST_HOLD) && (nxt_state == ST_RUN);
    wire logic [IRQ_W-1:0] irq_set = {resume, enter_shut};

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            ctrl_ff  <= CTRL_RESET;
            cfg_ff   <= CFG_RESET;
            dband_ff <= DBAND_RESET;
            imask_ff <= IMASK_RESET;
        end else begin
            ctrl_ff.shutdown <= nxt_sd;
            if (wr_ctrl) begin
                ctrl_ff.restart_en                <= wdata_in[CTRL_REN_BIT]; // R3
                ctrl_ff.pair_bd_safe_level_select <= wss_safe_e'(wdata_in[5:4]);
                ctrl_ff.pair_ac_safe_level_select <= wss_safe_e'(wdata_in[3:2]);
            end
            if (wr_cfg) begin
                cfg_ff <= {3'h0, wdata_in[4:0]};
            end
            if (wr_dband) begin
                dband_ff <= wdata_in[DBAND_W-1:0];
            end
            if (wr_imask) begin
                imask_ff <= wdata_in[IRQ_W-1:0];
            end
        end
    end

    // Read clears the status, but an event in the same cycle still sets it
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            istat_ff <= 2'h0;
            irq_out  <= 1'b0;
        end else begin
            istat_ff <= (rd_istat ? 2'h0 : istat_ff) | irq_set;
            irq_out  <= |(((rd_istat ? 2'h0 : istat_ff) | irq_set) & imask_ff);
        end
    end

    wire logic [DATA_W-1:0] rd_mux =
        (addr_in == OFF_CTRL)  ? {ctrl_ff.shutdown, ctrl_ff.restart_en, ctrl_ff.pair_bd_safe_level_select,
                                  ctrl_ff.pair_ac_safe_level_select, 2'h0} :
        (addr_in == OFF_CFG)   ? DATA_W'(cfg_ff) :
        (addr_in == OFF_DBAND) ? {4'h0, dband_ff} :
        (addr_in == OFF_ISTAT) ? {6'h0, istat_ff} :
        (addr_in == OFF_IMASK) ? {6'h0, imask_ff} : 8'h00;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= rd_in ? rd_mux : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Shutdown sequencing
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_RUN: begin
                if (ctrl_ff.shutdown) begin
                    nxt_state = ST_SHUT;
                end
            end
            ST_SHUT: begin
                if (!ctrl_ff.shutdown) begin
                    nxt_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (ctrl_ff.shutdown) begin
                    nxt_state = ST_SHUT;
                end else if (src_ris) begin
                    nxt_state = ST_RUN; // R5
                end
            end
            default: nxt_state = ST_RUN;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            state_ff <= ST_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // Output drive
    // ----------------------------------------------------------------
    logic a_on;
    logic b_on;
    logic settled;

    wss_deadband u_deadband (
        .clk_sys_in  (clk_sys_in),
        .rst_b_in    (rst_b_in),
        .src_in      (src & cfg_ff.enable),
        .restart_in  (enter_shut),
        .db_len_in   (dband_ff),
        .a_on_out    (a_on),
        .b_on_out    (b_on),
        .settled_out (settled)
    );

    // Safe state holds in HOLD too, so the pins never glitch before the edge
    wire logic          safe = (state_ff != ST_RUN); // R5
    logic [NUM_OUT-1:0] val_ff;
    logic [NUM_OUT-1:0] oe_ff;
    // A disabled generator parks every pin at its plain polarity level
    wire  logic [NUM_OUT-1:0] live_on = {b_on, a_on, b_on, a_on} & {NUM_OUT{cfg_ff.enable}};

    generate
        for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
            // Even index is the A/C pair, odd index the B/D pair
            wire wss_safe_e sel = (i % 2 == 0) ? ctrl_ff.pair_ac_safe_level_select  // R2
                                               : ctrl_ff.pair_bd_safe_level_select; // R1
            wire wss_pin_s  sp  = wss_safe_pin(sel, val_ff[i], settled, cfg_ff.polarity[i]); // R1 R2

            always_ff @(posedge clk_sys_in) begin
                if (!rst_b_in) begin
                    val_ff[i] <= 1'b0;
                    oe_ff[i]  <= 1'b0;
                end else if (safe) begin
                    val_ff[i] <= sp.value;
                    oe_ff[i]  <= sp.oe;
                end else begin
                    val_ff[i] <= live_on[i] ^ cfg_ff.polarity[i];
                    oe_ff[i]  <= 1'b1;
                end
            end
        end
    endgenerate

    assign output_a_out    = val_ff[0];
    assign output_a_oe_out = oe_ff[0];
    assign output_b_out    = val_ff[1];
    assign output_b_oe_out = oe_ff[1];
    assign output_c_out    = val_ff[2];
    assign output_c_oe_out = oe_ff[2];
    assign output_d_out    = val_ff[3];
    assign output_d_oe_out = oe_ff[3];

endmodule

// *** hw/wss_pkg.sv ***
// Package for the waveform output safe-state control block: map, fields, types
package wss_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 8;
    localparam logic [7:0]  OFF_CTRL    = 8'h00;
    localparam logic [7:0]  OFF_CFG     = 8'h01;
    localparam logic [7:0]  OFF_DBAND   = 8'h02;
    localparam logic [7:0]  OFF_ISTAT   = 8'h03;
    localparam logic [7:0]  OFF_IMASK   = 8'h04;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int          CTRL_SD_BIT    = 7;
    localparam int          CTRL_REN_BIT   = 6;
    localparam int          IRQ_SD_BIT     = 0;
    localparam int          IRQ_RESUME_BIT = 1;
    localparam int          IRQ_W          = 2;
    localparam int          DBAND_W        = 4;
    localparam int          NUM_OUT        = 4;
    localparam logic [7:0]  CTRL_RESET     = 8'h14;
    localparam logic [7:0]  CFG_RESET      = 8'h00;
    localparam logic [3:0]  DBAND_RESET    = 4'h0;
    localparam logic [1:0]  IMASK_RESET    = 2'h0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SAFE_INACTIVE = 2'b00,
        SAFE_TRISTATE = 2'b01,
        SAFE_LOW      = 2'b10,
        SAFE_HIGH     = 2'b11
    } wss_safe_e;

    typedef struct packed {
        logic       shutdown;
        logic       restart_en;
        wss_safe_e  pair_bd_safe_level_select;
        wss_safe_e  pair_ac_safe_level_select;
        logic [1:0] rsvd;
    } wss_ctrl_s;

    typedef struct packed {
        logic [2:0] rsvd;
        logic [3:0] polarity;
        logic       enable;
    } wss_cfg_s;

    typedef struct packed {
        logic value;
        logic oe;
    } wss_pin_s;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_SHUT = 2'b01,
        ST_HOLD = 2'b11
    } wss_state_e;

    // Pin level for one output while in the safe state
    function automatic wss_pin_s wss_safe_pin(input wss_safe_e sel, input logic held,
                                              input logic settled, input logic pol);
        wss_pin_s p;
        p = '{value: held, oe: 1'b1};
        case (sel)
            SAFE_HIGH:     p.value = 1'b1;
            SAFE_LOW:      p.value = 1'b0;
            SAFE_TRISTATE: p = '{value: 1'b0, oe: 1'b0};
            default:       p.value = settled ? pol : held;
        endcase
        return p;
    endfunction

endpackage

// *** hw/wss_deadband.sv ***
// Complementary dead-band timer for the A/C and B/D output pairs
module wss_deadband
    import wss_pkg::*;
(
    input  wire logic               clk_sys_in,
    input  wire logic               rst_b_in,
    input  wire logic               src_in,
    input  wire logic               restart_in,
    input  wire logic [DBAND_W-1:0] db_len_in,
    output wire logic               a_on_out,
    output wire logic               b_on_out,
    output wire logic               settled_out
);

    logic [DBAND_W-1:0] cnt_ff;
    logic               prev_ff;
    wire  logic         change = (src_in != prev_ff) | restart_in;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            cnt_ff  <= DBAND_RESET;
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= src_in;
            if (change) begin
                cnt_ff <= DBAND_RESET;
            end else if (cnt_ff != db_len_in) begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

    // Both sides stay off until the interval after each edge has run out
    assign settled_out = !change && (cnt_ff == db_len_in);
    assign a_on_out    = src_in & settled_out;
    assign b_on_out    = ~src_in & settled_out;

endmodule

// *** bench/wss_asserts.sv ***
// Checker of the safe-state control block, bound to its top module
module wss_asserts
    import wss_pkg::*;
(
    input wire logic       clk_sys_in,
    input wire logic       rst_b_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic       shutdown_evt_in,
    input wire logic       wave_src_in,
    input wire logic       output_a_out,
    input wire logic       output_a_oe_out,
    input wire logic       output_b_out,
    input wire logic       output_b_oe_out,
    input wire logic       output_c_out,
    input wire logic       output_c_oe_out,
    input wire logic       output_d_out,
    input wire logic       output_d_oe_out,
    input wire logic       irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    logic [1:0] ac_ff, bd_ff, msk_ff;
    logic       ren_ff, en_ff;
    // Shadow copies of the software fields; hardware never alters them
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            {ren_ff, bd_ff, ac_ff} <= CTRL_RESET[6:2];
            en_ff                  <= 1'b0;
            msk_ff                 <= IMASK_RESET;
        end else if (wr_in) begin
            if (addr_in == OFF_CTRL) {ren_ff, bd_ff, ac_ff} <= wdata_in[6:2];
            if (addr_in == OFF_CFG) en_ff <= wdata_in[0];
            if (addr_in == OFF_IMASK) msk_ff <= wdata_in[1:0];
        end
    end
    function automatic logic pin_ok(input logic [1:0] sel, input logic v, input logic oe);
        case (sel)
            2'h3: pin_ok = v && oe;
            2'h2: pin_ok = !v && oe;
            2'h1: pin_ok = !oe;
            default: pin_ok = 1'b1;
        endcase
    endfunction
    sequence s_evt_held;
        shutdown_evt_in [*8];
    endsequence
    sequence s_fresh_evt;
        $rose(shutdown_evt_in) ##1 (shutdown_evt_in && !rd_in) [*7];
    endsequence
    sequence s_calm;
        (!shutdown_evt_in && !wave_src_in) [*6];
    endsequence
    sequence s_src_high;
        (!shutdown_evt_in && wave_src_in) [*8];
    endsequence
    chk_bd_safe_level: assert property (
        s_evt_held |-> pin_ok(bd_ff, output_b_out, output_b_oe_out) && pin_ok(bd_ff, output_d_out, output_d_oe_out))
        else $error("B/D pins off their safe level");
    chk_ac_safe_level: assert property (
        s_evt_held |-> pin_ok(ac_ff, output_a_out, output_a_oe_out) && pin_ok(ac_ff, output_c_out, output_c_oe_out))
        else $error("A/C pins off their safe level");
    chk_auto_restart: assert property (
        s_calm ##1 s_src_high ##0 (ren_ff && en_ff) |-> output_a_oe_out && output_c_oe_out)
        else $error("no automatic recovery");
    chk_force_safe: assert property (
        wr_in && addr_in == OFF_CTRL && wdata_in[7] && !en_ff && wdata_in[3:2] == 2'b01 |-> ##[2:5] !output_a_oe_out)
        else $error("software force not applied");
    chk_hold_until_edge: assert property (
        (!wave_src_in) [*4] ##0 !output_a_oe_out |=> !output_a_oe_out)
        else $error("safe level left without input edge");
    chk_entry_irq: assert property (
        s_fresh_evt ##0 msk_ff[0] |-> irq_out)
        else $error("shutdown entry raised no interrupt");
    chk_irq_masked: assert property (
        (msk_ff == 2'h0) [*2] |-> !irq_out)
        else $error("interrupt while fully masked");
endmodule

bind wss_top wss_asserts u_chk (.*);

// *** bench/wss_stage.sv ***
// Power stage model: gate inputs with pull-downs and a fault line back to the block
module wss_stage (
    input  wire logic       clk_sys_in,
    input  wire logic [3:0] pin_in,
    input  wire logic [3:0] oe_in,
    input  wire logic       fault_req_in,
    output logic      [3:0] gate_out,
    output logic            fault_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // A released gate input falls to its pull-down, never keeps the last level
    assign gate_out = pin_in & oe_in;
    // Fault comparator is filtered by one flop, as a real stage would be
    always @(posedge clk_sys_in) fault_out <= fault_req_in;
endmodule

// *** bench/tb_top.sv ***
// Self-checking bench of the safe-state control block with a power stage model
module tb_top
    import wss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_in  = 1'b0;
    logic        rst_b_in    = 1'b0;
    logic        wr_in       = 1'b0;
    logic        rd_in       = 1'b0;
    logic        rd_d        = 1'b0;
    logic        wave_src_in = 1'b0;
    logic        fault_req   = 1'b0;
    logic [7:0]  addr_in     = 8'h00;
    logic [7:0]  wdata_in    = 8'h00;
    logic [3:0]  pol         = 4'h0;
    logic [15:0] note;
    logic [15:0] exp_q[$];
    logic [31:0] seed        = 32'h0001_7491;
    wire  [7:0]  rdata_out;
    wire  [3:0]  pin, oe, gate;
    wire         evt, irq_out;
    int          error_cnt   = 0;
    int          checks_done = 0;
    int          cyc         = 0;
    wss_top dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .shutdown_evt_in(evt), .wave_src_in(wave_src_in),
        .output_a_out(pin[0]), .output_a_oe_out(oe[0]), .output_b_out(pin[1]), .output_b_oe_out(oe[1]),
        .output_c_out(pin[2]), .output_c_oe_out(oe[2]), .output_d_out(pin[3]), .output_d_oe_out(oe[3]),
        .irq_out(irq_out));
    wss_stage stage (.clk_sys_in(clk_sys_in), .pin_in(pin), .oe_in(oe), .fault_req_in(fault_req),
        .gate_out(gate), .fault_out(evt));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic give_verdict;
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] e, input logic [7:0] m);
        checks_done++;
        if ((got & m) !== (e & m)) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        wr_in    <= 1'b1;
        addr_in  <= a;
        wdata_in <= d;
        @(posedge clk_sys_in);
        wr_in    <= 1'b0;
    endtask
    // The expectation is queued here and consumed by the read monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        @(posedge clk_sys_in);
        rd_in   <= 1'b1;
        addr_in <= a;
        exp_q.push_back({m, e});
        @(posedge clk_sys_in);
        rd_in   <= 1'b0;
    endtask
    // Pin value is only compared where the pin is driven
    task automatic pins(input int i, input logic [1:0] sel);
        logic [7:0] e;
        e = {6'h00, (sel == SAFE_INACTIVE) ? pol[i] : sel[0], sel != SAFE_TRISTATE};
        // A released gate input must sit at its pull-down level
        e[2] = e[1] & e[0];
        cmp({5'h00, gate[i], pin[i], oe[i]}, e, (sel == SAFE_TRISTATE) ? 8'h05 : 8'h07);
    endtask
    always #5 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        rd_d <= rd_in;
        cyc  <= cyc + 1;
        if (rd_d === 1'b1) begin
            note = exp_q.pop_front();
            cmp(rdata_out, note[7:0], note[15:8]);
        end
        if (cyc == 3000) begin
            error_cnt++;
            $display("MISMATCH t=%0t timeout", $time);
            give_verdict();
        end
    end
    initial begin
        tick(2);
        rst_b_in <= 1'b1;
        rd(OFF_CTRL, CTRL_RESET);
        rd(8'h07, 8'h00);
        wr(OFF_IMASK, 8'h01);
        wr(OFF_CTRL, 8'hB4);
        tick(4);
        pins(0, SAFE_TRISTATE);
        pins(1, SAFE_HIGH);
        wr(OFF_CTRL, 8'h34);
        tick(6);
        pins(2, SAFE_TRISTATE);
        wave_src_in <= 1'b1;
        tick(6);
        pins(2, SAFE_INACTIVE);
        seed = lfsr(seed);
        pol  = seed[3:0];
        wr(OFF_CFG, {3'h0, pol, 1'b1});
        wr(OFF_DBAND, {4'h0, seed[7:4]});
        rd(OFF_ISTAT, 8'h03);
        for (int k = 0; k < 4; k++) begin
            wave_src_in <= 1'b0;
            wr(OFF_CTRL, {2'b01, k[1:0], 2'(3 - k), 2'b00});
            fault_req <= 1'b1;
            tick(30);
            pins(1, k[1:0]);
            pins(3, k[1:0]);
            pins(0, 2'(3 - k));
            pins(2, 2'(3 - k));
            cmp({7'h00, irq_out}, 8'h01, 8'h01);
            rd(OFF_CTRL, 8'h80, 8'h80);
            rd(OFF_ISTAT, 8'h01, 8'h01);
            tick(3);
            cmp({7'h00, irq_out}, 8'h00, 8'h01);
            fault_req <= 1'b0;
            tick(10);
            rd(OFF_CTRL, 8'h00, 8'h80);
            wave_src_in <= 1'b1;
            tick(10);
            cmp({6'h00, oe[2], oe[0]}, 8'h03, 8'h03);
        end
        wave_src_in <= 1'b0;
        wr(OFF_CTRL, 8'h14);
        fault_req <= 1'b1;
        tick(12);
        fault_req <= 1'b0;
        tick(12);
        rd(OFF_CTRL, 8'h94);
        pins(0, SAFE_TRISTATE);
        wr(OFF_CTRL, 8'h14);
        tick(4);
        wave_src_in <= 1'b1;
        tick(8);
        cmp({7'h00, oe[0]}, 8'h01, 8'h01);
        wr(OFF_CTRL, 8'h94);
        rd(OFF_CTRL, 8'h14);
        tick(2);
        rst_b_in <= 1'b0;
        tick(2);
        rst_b_in <= 1'b1;
        rd(OFF_CFG, CFG_RESET);
        tick(2);
        give_verdict();
    end
endmodule
